/* File: rtl/tmc_map.vh */
`ifndef TMC_MAP_VH
`define TMC_MAP_VH

// Byte register addresses on the CPU port.
`define TMC_A_CNT_L      4'h0
`define TMC_A_CNT_H      4'h1
`define TMC_A_CMPA_L     4'h2
`define TMC_A_CMPA_H     4'h3
`define TMC_A_CMPB_L     4'h4
`define TMC_A_CMPB_H     4'h5
`define TMC_A_CMPC_L     4'h6
`define TMC_A_CMPC_H     4'h7
`define TMC_A_FLAGS      4'h8
`define TMC_A_FORCE      4'h9

// Bit position of the overflow flag in the flag register.
`define TMC_B_OVF        3

// Waveform mode codes.
`define TMC_M_NORMAL     4'h0
`define TMC_M_PC8        4'h1
`define TMC_M_PC9        4'h2
`define TMC_M_PC10       4'h3
`define TMC_M_CTC_CMP    4'h4
`define TMC_M_FAST8      4'h5
`define TMC_M_FAST9      4'h6
`define TMC_M_FAST10     4'h7
`define TMC_M_PFC_CAP    4'h8
`define TMC_M_PFC_CMP    4'h9
`define TMC_M_PC_CAP     4'ha
`define TMC_M_PC_CMP     4'hb
`define TMC_M_CTC_CAP    4'hc
`define TMC_M_RSVD       4'hd
`define TMC_M_FAST_CAP   4'he
`define TMC_M_FAST_CMP   4'hf

// Counter boundary values.
`define TMC_TOP8         16'h00ff
`define TMC_TOP9         16'h01ff
`define TMC_TOP10        16'h03ff
`define TMC_MAX          16'hffff
`define TMC_BOTTOM       16'h0000

// Compare output actions.
`define TMC_ACT_NONE     2'h0
`define TMC_ACT_TOGGLE   2'h1
`define TMC_ACT_CLEAR    2'h2
`define TMC_ACT_SET      2'h3

// Reset values.
`define TMC_RST_OC       1'b0
`define TMC_RST_CMP      16'h0000
`define TMC_RST_BYTE     8'h00

`endif

/* File: rtl/tmc_cmp_reg.v */
`timescale 1ns/1ps
`include "tmc_map.vh"

// One compare value with its buffer register.
module tmc_cmp_reg (
	// Clock and reset.
	input  wire        ref_clk,
	input  wire        rst,
	// Write of both bytes at once, on the low-byte write.
	input  wire        wr,
	input  wire [15:0] wdata,
	// Buffering control.
	input  wire        buffered,
	input  wire        load,
	// Register contents.
	output wire [15:0] cmp_act,
	output wire [15:0] cmp_buf
);

reg [15:0] act_r;
reg [15:0] buf_r;

// Buffered writes wait in the buffer until the boundary load.
always @(posedge ref_clk or posedge rst) begin
	if (rst) begin
		act_r <= `TMC_RST_CMP;
		buf_r <= `TMC_RST_CMP;
	end else begin
		if (wr) begin
			buf_r <= wdata;
		end
		if (wr && !buffered) begin
			act_r <= wdata;
		end else if (load && buffered) begin
			act_r <= buf_r;
		end
	end
end

assign cmp_act = act_r;
assign cmp_buf = buf_r;

endmodule // tmc_cmp_reg

/* File: rtl/tmc_compare.v */
`timescale 1ns/1ps
`include "tmc_map.vh"


module tmc_compare (
	// Clock and reset.
	input  wire        ref_clk,
	input  wire        rst,
	// Prescaled timer clock, one pulse per timer clock.
	input  wire        timer_tick,
	// Byte register port from the CPU.
	input  wire        reg_wr,
	input  wire        reg_rd,
	input  wire [3:0]  reg_addr,
	input  wire [7:0]  reg_wdata,
	output wire [7:0]  reg_rdata,
	// Configuration.
	input  wire [3:0]  waveform_mode_select,
	input  wire [5:0]  compare_output_action,
	input  wire [2:0]  compare_irq_enable,
	input  wire        overflow_irq_enable,
	input  wire [15:0] capture_value,
	// Interrupt execution acknowledges.
	input  wire [2:0]  compare_irq_ack,
	input  wire        overflow_irq_ack,
	// Port pin control.
	input  wire [2:0]  output_pin_direction,
	input  wire [2:0]  port_value,
	output wire [2:0]  pin_out,
	output wire [2:0]  pin_oe,
	// Status and interrupt requests.
	output wire [15:0] timer_count,
	output wire [2:0]  compare_match_flag,
	output wire        overflow_flag,
	output wire [2:0]  compare_output,
	output wire [2:0]  compare_irq,
	output wire        overflow_irq
);

// Counter and shared staging state.
reg  [15:0] cnt_r;
reg  [15:0] cnt_nxt;
reg         dir_up_r;
reg         dir_up_nxt;
reg  [7:0]  temp_r;
reg         block_r;
reg         ovf_r;
reg         ovf_irq_r;
reg  [7:0]  rdata_r;
reg  [7:0]  rd_mux;

// Mode decode.
reg         is_pwm;
reg         is_fast;
reg         is_phase;
reg         load_bottom;
reg  [15:0] top_val;

// Boundary events.
reg         ovf_evt;
wire        top_hit;
wire        bottom_evt;
wire        wrap_evt;
wire        buf_load;

// Write decode.
wire        wr_cnt_lo;
wire        wr_hi;
wire        wr_flags;
wire        wr_force;

// Per-channel compare values, packed A in the low word.
wire [47:0] cmp_act_w;
wire [47:0] cmp_buf_w;
wire [47:0] cmp_view;

assign wr_cnt_lo = reg_wr && (reg_addr == `TMC_A_CNT_L);
assign wr_flags  = reg_wr && (reg_addr == `TMC_A_FLAGS);
assign wr_force  = reg_wr && (reg_addr == `TMC_A_FORCE);

// Every high-byte write goes to the one shared staging byte.
assign wr_hi = reg_wr && ((reg_addr == `TMC_A_CNT_H) ||
	(reg_addr == `TMC_A_CMPA_H) || (reg_addr == `TMC_A_CMPB_H) ||
	(reg_addr == `TMC_A_CMPC_H));

// Mode classes, TOP source and the buffer load point.
always @* begin
	is_pwm      = 1'b1;
	is_fast     = 1'b0;
	is_phase    = 1'b0;
	load_bottom = 1'b0;
	top_val     = `TMC_MAX;
	case (waveform_mode_select)
	`TMC_M_NORMAL, `TMC_M_RSVD: begin
		is_pwm = 1'b0;
	end
	`TMC_M_CTC_CMP: begin
		is_pwm  = 1'b0;
		top_val = cmp_act_w[15:0];
	end
	`TMC_M_CTC_CAP: begin
		is_pwm  = 1'b0;
		top_val = capture_value;
	end
	`TMC_M_FAST8: begin
		is_fast = 1'b1;
		top_val = `TMC_TOP8;
	end
	`TMC_M_FAST9: begin
		is_fast = 1'b1;
		top_val = `TMC_TOP9;
	end
	`TMC_M_FAST10: begin
		is_fast = 1'b1;
		top_val = `TMC_TOP10;
	end
	`TMC_M_FAST_CAP: begin
		is_fast = 1'b1;
		top_val = capture_value;
	end
	`TMC_M_FAST_CMP: begin
		is_fast = 1'b1;
		top_val = cmp_act_w[15:0];
	end
	`TMC_M_PC8: begin
		is_phase = 1'b1;
		top_val  = `TMC_TOP8;
	end
	`TMC_M_PC9: begin
		is_phase = 1'b1;
		top_val  = `TMC_TOP9;
	end
	`TMC_M_PC10: begin
		is_phase = 1'b1;
		top_val  = `TMC_TOP10;
	end
	`TMC_M_PFC_CAP: begin
		is_phase    = 1'b1;
		load_bottom = 1'b1;
		top_val     = capture_value;
	end
	`TMC_M_PFC_CMP: begin
		is_phase    = 1'b1;
		load_bottom = 1'b1;
		top_val     = cmp_act_w[15:0];
	end
	`TMC_M_PC_CAP: begin
		is_phase = 1'b1;
		top_val  = capture_value;
	end
	`TMC_M_PC_CMP: begin
		is_phase = 1'b1;
		top_val  = cmp_act_w[15:0];
	end
	default: begin
		is_pwm = 1'b0;
	end
	endcase
end

// A blocked cycle also hides the TOP match, so a count loaded at TOP
// runs on to the maximum before wrapping.
assign top_hit    = (cnt_r == top_val) && !block_r;
assign bottom_evt = timer_tick && is_phase && !dir_up_r &&
	(cnt_r == `TMC_BOTTOM);
assign wrap_evt   = timer_tick && is_fast && top_hit;

// Buffered compares move only at a period boundary.
assign buf_load = is_fast ? wrap_evt :
	(is_phase && (load_bottom ? bottom_evt :
	(timer_tick && dir_up_r && top_hit)));

// Next count from the mode; the action bits play no part here.
always @* begin
	cnt_nxt    = cnt_r;
	dir_up_nxt = 1'b1;
	ovf_evt    = 1'b0;
	if (is_phase) begin
		dir_up_nxt = dir_up_r;
		if (dir_up_r) begin
			if (top_hit) begin
				dir_up_nxt = 1'b0;
				cnt_nxt    = cnt_r - 16'h0001;
			end else begin
				cnt_nxt = cnt_r + 16'h0001;
			end
		end else if (cnt_r == `TMC_BOTTOM) begin
			dir_up_nxt = 1'b1;
			cnt_nxt    = cnt_r + 16'h0001;
			ovf_evt    = 1'b1;
		end else begin
			cnt_nxt = cnt_r - 16'h0001;
		end
	end else if (is_fast) begin
		cnt_nxt = top_hit ? `TMC_BOTTOM : (cnt_r + 16'h0001);
		ovf_evt = top_hit;
	end else if (waveform_mode_select == `TMC_M_NORMAL) begin
		cnt_nxt = cnt_r + 16'h0001;
		ovf_evt = (cnt_r == `TMC_MAX);
	end else begin
		cnt_nxt = top_hit ? `TMC_BOTTOM : (cnt_r + 16'h0001);
		ovf_evt = (cnt_r == `TMC_MAX);
	end
end

// Counter, direction and match blocking.
always @(posedge ref_clk or posedge rst) begin
	if (rst) begin
		cnt_r    <= `TMC_BOTTOM;
		dir_up_r <= 1'b1;
		block_r  <= 1'b0;
	end else begin
		if (wr_cnt_lo) begin
			cnt_r   <= {temp_r, reg_wdata};
			block_r <= 1'b1;
		end else if (timer_tick) begin
			cnt_r    <= cnt_nxt;
			dir_up_r <= dir_up_nxt;
			block_r  <= 1'b0;
		end
	end
end

// Shared staging byte: loaded by high-byte writes and low count reads.
always @(posedge ref_clk or posedge rst) begin
	if (rst) begin
		temp_r <= `TMC_RST_BYTE;
	end else if (wr_hi) begin
		temp_r <= reg_wdata;
	end else if (reg_rd && (reg_addr == `TMC_A_CNT_L)) begin
		temp_r <= cnt_r[15:8];
	end
end

// Overflow flag: a set in the same cycle as a clear wins.
always @(posedge ref_clk or posedge rst) begin
	if (rst) begin
		ovf_r     <= 1'b0;
		ovf_irq_r <= 1'b0;
	end else begin
		ovf_r <= (timer_tick && ovf_evt && !wr_cnt_lo) ||
			(ovf_r && !overflow_irq_ack &&
			!(wr_flags && reg_wdata[`TMC_B_OVF]));
		ovf_irq_r <= ovf_r && overflow_irq_enable;
	end
end

// Compare registers, flags and waveform outputs for A, B and C.
genvar i;
generate
	for (i = 0; i < 3; i = i + 1) begin : g_ch
		localparam integer LO_ADDR = `TMC_A_CMPA_L + 2 * i;
		wire [1:0]  act;
		wire [15:0] cmp;
		wire        wr_lo;
		wire        match;
		wire        hit;
		wire        force_now;
		reg         oc_r;
		reg         oc_nxt;
		reg         flag_r;
		reg         irq_r;
		reg         pin_r;
		reg         oe_r;

		assign act       = compare_output_action[2*i+1:2*i];
		assign wr_lo     = reg_wr && (reg_addr == LO_ADDR[3:0]);
		assign cmp       = cmp_act_w[16*i+15:16*i];
		assign match     = (cnt_r == cmp) && !block_r;
		assign hit       = timer_tick && match && !wr_cnt_lo;
		assign force_now = wr_force && reg_wdata[i] && !is_pwm;
		assign cmp_view[16*i+15:16*i] = is_pwm ?
			cmp_buf_w[16*i+15:16*i] : cmp;

		tmc_cmp_reg u_cmp (
			.ref_clk  (ref_clk),
			.rst      (rst),
			.wr       (wr_lo),
			.wdata    ({temp_r, reg_wdata}),
			.buffered (is_pwm),
			.load     (buf_load),
			.cmp_act  (cmp_act_w[16*i+15:16*i]),
			.cmp_buf  (cmp_buf_w[16*i+15:16*i])
		);

		// Next output state; the current action is always used.
		always @* begin
			oc_nxt = oc_r;
			if (!is_pwm) begin
				if (hit || force_now) begin
					case (act)
					`TMC_ACT_TOGGLE: oc_nxt = !oc_r;
					`TMC_ACT_CLEAR:  oc_nxt = 1'b0;
					`TMC_ACT_SET:    oc_nxt = 1'b1;
					default:         oc_nxt = oc_r;
					endcase
				end
			end else if (is_fast) begin
				if (hit) begin
					case (act)
					`TMC_ACT_TOGGLE: oc_nxt = !oc_r;
					`TMC_ACT_CLEAR:  oc_nxt = 1'b0;
					`TMC_ACT_SET:    oc_nxt = 1'b1;
					default:         oc_nxt = oc_r;
					endcase
				end
				// BOTTOM wins for clear and set, so a compare at TOP gives a steady level.
				if (wrap_evt) begin
					case (act)
					`TMC_ACT_CLEAR: oc_nxt = 1'b1;
					`TMC_ACT_SET:   oc_nxt = 1'b0;
					default:        oc_nxt = oc_nxt;
					endcase
				end
			end else if (hit) begin
				case (act)
				`TMC_ACT_TOGGLE: oc_nxt = !oc_r;
				`TMC_ACT_CLEAR:  oc_nxt = !dir_up_r;
				`TMC_ACT_SET:    oc_nxt = dir_up_r;
				default:         oc_nxt = oc_r;
				endcase
			end
		end

		// Output state, flag and interrupt; a set beats a clear.
		always @(posedge ref_clk or posedge rst) begin
			if (rst) begin
				oc_r   <= `TMC_RST_OC;
				flag_r <= 1'b0;
				irq_r  <= 1'b0;
				pin_r  <= 1'b0;
				oe_r   <= 1'b0;
			end else begin
				oc_r   <= oc_nxt;
				flag_r <= hit || (flag_r && !compare_irq_ack[i] &&
					!(wr_flags && reg_wdata[i]));
				irq_r  <= flag_r && compare_irq_enable[i];
				pin_r  <= (act != `TMC_ACT_NONE) ? oc_r :
					port_value[i];
				oe_r   <= output_pin_direction[i];
			end
		end

		assign compare_output[i]     = oc_r;
		assign compare_match_flag[i] = flag_r;
		assign compare_irq[i]        = irq_r;
		assign pin_out[i]            = pin_r;
		assign pin_oe[i]             = oe_r;
	end
endgenerate

// Read data; compare bytes come from the buffer in PWM modes, else from the register in use.
always @* begin
	case (reg_addr)
	`TMC_A_CNT_L:  rd_mux = cnt_r[7:0];
	`TMC_A_CNT_H:  rd_mux = temp_r;
	`TMC_A_CMPA_L: rd_mux = cmp_view[7:0];
	`TMC_A_CMPA_H: rd_mux = cmp_view[15:8];
	`TMC_A_CMPB_L: rd_mux = cmp_view[23:16];
	`TMC_A_CMPB_H: rd_mux = cmp_view[31:24];
	`TMC_A_CMPC_L: rd_mux = cmp_view[39:32];
	`TMC_A_CMPC_H: rd_mux = cmp_view[47:40];
	`TMC_A_FLAGS:  rd_mux = {4'h0, ovf_r, compare_match_flag};
	`TMC_A_FORCE:  rd_mux = 8'h00;
	default:       rd_mux = 8'h00;
	endcase
end

// Read data register, updated on each read strobe.
always @(posedge ref_clk or posedge rst) begin
	if (rst) begin
		rdata_r <= `TMC_RST_BYTE;
	end else if (reg_rd) begin
		rdata_r <= rd_mux;
	end
end

assign reg_rdata     = rdata_r;
assign timer_count   = cnt_r;
assign overflow_flag = ovf_r;
assign overflow_irq  = ovf_irq_r;

endmodule // tmc_compare

/* File: verif/tmc_compare_checker.sv */
`timescale 1ns/1ps
// Port-level timing checks for the compare block.
module tmc_compare_checker (
	// Clock and reset.
	input logic        ref_clk,
	input logic        rst,
	input logic        timer_tick,
	// Byte port.
	input logic        reg_wr,
	input logic [3:0]  reg_addr,
	input logic [7:0]  reg_wdata,
	// Configuration and pins.
	input logic [3:0]  waveform_mode_select,
	input logic [5:0]  compare_output_action,
	input logic [2:0]  compare_irq_enable,
	input logic [2:0]  compare_irq_ack,
	input logic [2:0]  output_pin_direction,
	input logic [2:0]  port_value,
	input logic [2:0]  pin_out,
	input logic [2:0]  pin_oe,
	// Status.
	input logic [15:0] timer_count,
	input logic [2:0]  compare_match_flag,
	input logic        overflow_flag,
	input logic [2:0]  compare_output,
	input logic [2:0]  compare_irq
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);
	// Low byte write to the counter.
	wire cnt_wr = reg_wr && reg_addr == 4'h0;
	wire mode0 = waveform_mode_select == 4'h0;

	// A flag only rises on a timer tick edge.
	property p_flag_tick;
		$rose(compare_match_flag[0]) |-> $past(timer_tick);
	endproperty
	a_flag_tick: assert property (p_flag_tick)
		else $error("flag rose without a tick");
	property p_irq;
		1 |=> compare_irq == $past(compare_match_flag & compare_irq_enable);
	endproperty
	a_irq: assert property (p_irq)
		else $error("compare request does not follow flag and enable");
	property p_ack;
		compare_irq_ack[0] && !timer_tick |=> !compare_match_flag[0];
	endproperty
	a_ack: assert property (p_ack)
		else $error("acknowledge did not clear flag");
	property p_w1c;
		reg_wr && reg_addr == 4'h8 && reg_wdata[0] && !timer_tick
			|=> !compare_match_flag[0];
	endproperty
	a_w1c: assert property (p_w1c)
		else $error("write one did not clear flag");
	// The first tick after a counter write must leave match flags and compare outputs unchanged.
	property p_block;
		cnt_wr ##1 !timer_tick ##1 (timer_tick && !reg_wr
			&& compare_irq_ack == 3'h0) |=> $stable(compare_match_flag)
			&& $stable(compare_output);
	endproperty
	a_block: assert property (p_block)
		else $error("match not blocked after counter write");
	property p_force;
		reg_wr && reg_addr == 4'h9 && reg_wdata[2] && mode0
			&& compare_output_action[5:4] == 2'h1 && !timer_tick
			|=> compare_output[2] != $past(compare_output[2])
			&& compare_match_flag[2] == $past(compare_match_flag[2]);
	endproperty
	a_force: assert property (p_force)
		else $error("force did not toggle or set a flag");
	property p_count;
		timer_tick && !reg_wr && mode0
			|=> timer_count == $past(timer_count) + 16'h0001;
	endproperty
	a_count: assert property (p_count)
		else $error("normal mode count did not step up");
	property p_wr_wins;
		cnt_wr |=> timer_count[7:0] == $past(reg_wdata);
	endproperty
	a_wr_wins: assert property (p_wr_wins)
		else $error("counter write lost");
	property p_ovf;
		timer_tick && !reg_wr && mode0 && timer_count == 16'hffff
			|=> overflow_flag;
	endproperty
	a_ovf: assert property (p_ovf)
		else $error("overflow flag not set at wrap");
	property p_pin;
		output_pin_direction[0] |=> pin_oe[0] && pin_out[0] ==
			($past(compare_output_action[1:0]) != 2'h0 ?
			$past(compare_output[0]) : $past(port_value[0]));
	endproperty
	a_pin: assert property (p_pin)
		else $error("pin override wrong");

	// Main scenarios reached.
	c_match: cover property ($rose(compare_match_flag[0]));
	c_force: cover property (reg_wr && reg_addr == 4'h9);
	c_ovf: cover property ($rose(overflow_flag));
endmodule // tmc_compare_checker

bind tmc_compare tmc_compare_checker i_tmc_compare_checker (
	.ref_clk(ref_clk), .rst(rst), .timer_tick(timer_tick),
	.reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.waveform_mode_select(waveform_mode_select),
	.compare_output_action(compare_output_action),
	.compare_irq_enable(compare_irq_enable),
	.compare_irq_ack(compare_irq_ack),
	.output_pin_direction(output_pin_direction),
	.port_value(port_value), .pin_out(pin_out), .pin_oe(pin_oe),
	.timer_count(timer_count), .compare_match_flag(compare_match_flag),
	.overflow_flag(overflow_flag), .compare_output(compare_output),
	.compare_irq(compare_irq));

/* File: verif/tmc_cpu_model.sv */
`timescale 1ns/1ps
// CPU side of the byte port; all changes land on the falling edge.
module tmc_cpu_model (
	// Clock.
	input  logic       ref_clk,
	// Byte port.
	output logic       reg_wr,
	output logic       reg_rd,
	output logic [3:0] reg_addr,
	output logic [7:0] reg_wdata,
	input  logic [7:0] reg_rdata
);
	// Idle port at time zero.
	initial begin
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 4'h0;
		reg_wdata = 8'h00;
	end
	// One byte write; data is scrambled once the strobe drops.
	task wr8(input logic [3:0] a, input logic [7:0] d);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge ref_clk);
		reg_wr = 1'b0;
		reg_wdata = ~d;
		@(negedge ref_clk);
	endtask
	// One byte read; data is valid after the read edge.
	task rd8(input logic [3:0] a, output logic [7:0] d);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge ref_clk);
		reg_rd = 1'b0;
		d = reg_rdata;
		@(negedge ref_clk);
	endtask
	// High byte to staging first, the low byte loads both.
	task wr16(input logic [3:0] a, input logic [15:0] d);
		wr8(a + 4'h1, d[15:8]);
		wr8(a, d[7:0]);
	endtask
endmodule // tmc_cpu_model

/* File: verif/test_tmc_compare.sv */
`timescale 1ns/1ps
// Directed tests of the compare block through its byte port.
module test_tmc_compare;
	// Stimulus.
	logic        ref_clk = 1'b0;
	logic        rst = 1'b1;
	logic        timer_tick = 1'b0;
	logic [3:0]  waveform_mode_select = 4'h0;
	logic [5:0]  compare_output_action = 6'h00;
	logic [2:0]  compare_irq_enable = 3'h0;
	logic        overflow_irq_enable = 1'b0;
	logic [2:0]  compare_irq_ack = 3'h0;
	logic        overflow_irq_ack = 1'b0;
	logic [2:0]  output_pin_direction = 3'h0;
	logic [2:0]  port_value = 3'h0;
	// Port and outputs.
	logic        reg_wr;
	logic        reg_rd;
	logic [3:0]  reg_addr;
	logic [7:0]  reg_wdata;
	logic [7:0]  reg_rdata;
	logic [2:0]  pin_out;
	logic [2:0]  pin_oe;
	logic [15:0] timer_count;
	logic [2:0]  compare_match_flag;
	logic        overflow_flag;
	logic [2:0]  compare_output;
	logic [2:0]  compare_irq;
	logic        overflow_irq;
	integer      err_total = 0;
	integer      samples_checked = 0;
	logic [7:0]  rb;

	tmc_compare i_tmc_compare (.ref_clk(ref_clk), .rst(rst),
		.timer_tick(timer_tick), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.waveform_mode_select(waveform_mode_select),
		.compare_output_action(compare_output_action),
		.compare_irq_enable(compare_irq_enable),
		.overflow_irq_enable(overflow_irq_enable),
		.capture_value(16'h0000), .compare_irq_ack(compare_irq_ack),
		.overflow_irq_ack(overflow_irq_ack),
		.output_pin_direction(output_pin_direction),
		.port_value(port_value), .pin_out(pin_out), .pin_oe(pin_oe),
		.timer_count(timer_count), .compare_match_flag(compare_match_flag),
		.overflow_flag(overflow_flag), .compare_output(compare_output),
		.compare_irq(compare_irq), .overflow_irq(overflow_irq));
	tmc_cpu_model i_tmc_cpu_model (.ref_clk(ref_clk), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata));

	// 40 MHz clock.
	always #12.5 ref_clk = ~ref_clk;

	// Compare and count.
	task chk(input logic [15:0] seen, input logic [15:0] exp);
		samples_checked = samples_checked + 1;
		if (seen !== exp) begin
			err_total = err_total + 1;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// Timer ticks, each followed by an idle cycle.
	task tick(input integer n);
		repeat (n) begin
			timer_tick = 1'b1;
			@(negedge ref_clk);
			timer_tick = 1'b0;
			@(negedge ref_clk);
		end
	endtask
	// Interrupt execution pulses.
	task ack(input logic [2:0] c, input logic o);
		compare_irq_ack = c;
		overflow_irq_ack = o;
		@(negedge ref_clk);
		compare_irq_ack = 3'h0;
		overflow_irq_ack = 1'b0;
		@(negedge ref_clk);
	endtask
	// Verdict and end of run.
	task stop_test;
		$display("checks=%0d errors=%0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// Watchdog.
	initial begin
		#200000;
		err_total = err_total + 1;
		stop_test;
	end

	// Test sequence.
	initial begin
		repeat (5) @(negedge ref_clk);
		rst = 1'b0;
		chk(compare_output, 16'h0000);
		compare_output_action = 6'h01;
		compare_irq_enable = 3'h1;
		i_tmc_cpu_model.wr16(4'h2, 16'h0104);
		i_tmc_cpu_model.wr16(4'h4, 16'h0103);
		i_tmc_cpu_model.wr16(4'h6, 16'h0004);
		i_tmc_cpu_model.wr16(4'h0, 16'h0103);
		tick(1);
		chk(compare_match_flag, 16'h0000);
		chk(timer_count, 16'h0104);
		tick(1);
		chk(compare_match_flag, 16'h0001);
		chk(compare_irq, 16'h0001);
		chk(compare_output, 16'h0001);
		i_tmc_cpu_model.rd8(4'h7, rb);
		chk(rb, 16'h0000);
		i_tmc_cpu_model.wr8(4'h8, 8'h00);
		chk(compare_match_flag, 16'h0001);
		i_tmc_cpu_model.wr8(4'h8, 8'h01);
		chk(compare_match_flag, 16'h0000);
		i_tmc_cpu_model.wr16(4'h0, 16'h0103);
		tick(2);
		chk(compare_output, 16'h0000);
		ack(3'h1, 1'b0);
		chk(compare_match_flag, 16'h0000);
		// Force with new actions: A sets, C toggles.
		compare_output_action = 6'h13;
		i_tmc_cpu_model.wr8(4'h9, 8'h05);
		chk(compare_output, 16'h0005);
		chk(compare_match_flag, 16'h0000);
		i_tmc_cpu_model.rd8(4'h9, rb);
		chk(rb, 16'h0000);
		output_pin_direction = 3'h7;
		port_value = 3'h2;
		repeat (2) @(negedge ref_clk);
		chk(pin_out, 16'h0007);
		chk(pin_oe, 16'h0007);
		compare_output_action = 6'h10;
		i_tmc_cpu_model.wr16(4'h0, 16'h0103);
		tick(2);
		chk(compare_output, 16'h0005);
		chk(timer_count, 16'h0105);
		i_tmc_cpu_model.wr8(4'h8, 8'h07);
		overflow_irq_enable = 1'b1;
		i_tmc_cpu_model.wr16(4'h0, 16'hfffe);
		tick(2);
		chk(timer_count, 16'h0000);
		chk(overflow_flag, 16'h0001);
		chk(overflow_irq, 16'h0001);
		ack(3'h0, 1'b1);
		chk(overflow_flag, 16'h0000);
		// Fast PWM, 8-bit TOP; B clears on match, sets at BOTTOM.
		waveform_mode_select = 4'h5;
		compare_output_action = 6'h08;
		i_tmc_cpu_model.wr16(4'h4, 16'h0010);
		i_tmc_cpu_model.rd8(4'h5, rb);
		chk(rb, 16'h0000);
		i_tmc_cpu_model.wr16(4'h0, 16'h000f);
		tick(2);
		chk(compare_match_flag, 16'h0000);
		// Counter loads stay clear of TOP.
		// A and C keep their forced state; B sets at BOTTOM.
		i_tmc_cpu_model.wr16(4'h0, 16'h00fe);
		tick(2);
		chk(compare_output, 16'h0007);
		// C matches at 4, B at its newly loaded 0x10.
		tick(17);
		chk(compare_match_flag, 16'h0006);
		chk(compare_output, 16'h0005);
		stop_test;
	end
endmodule // test_tmc_compare
